// file: inc/pmc_link_if.sv
// Purpose: carrier between the mode control top and its two helpers
// Assumes: all signals on the core clock
// Notes: stack bank side is clocked, address map side is combinational
`timescale 1ns/1ps
interface pmc_link_if;
    logic sp_wr;
    logic [31:0] sp_wdata;
    logic sel_psp;
    logic [31:0] active_sp;
    logic [31:0] addr;
    logic [1:0] size;
    logic [2:0] bus_sel;
    logic bb_hit;
    logic [31:0] bb_word;
    logic [4:0] bb_bit;
    logic unaligned;

    modport ctrl (
        output sp_wr, sp_wdata, sel_psp, addr, size,
        input active_sp, bus_sel, bb_hit, bb_word, bb_bit, unaligned
    );
    modport bank (
        input sp_wr, sp_wdata, sel_psp,
        output active_sp
    );
    modport map (
        input addr, size,
        output bus_sel, bb_hit, bb_word, bb_bit, unaligned
    );
endinterface

// file: inc/pmc_pkg.sv
// Purpose: shared constants and types of the privilege mode control block
// Assumes: one clock, synchronous active high reset
// Notes: bit-band bases are plain defaults for parameters; bit-band span and region figures are used directly
package pmc_pkg;
    // execution states, one-hot
    typedef enum logic [2:0] {
        PMC_PRIV_THREAD = 3'b001,
        PMC_USER_THREAD = 3'b010,
        PMC_HANDLER = 3'b100
    } pmc_state_t;

    typedef logic [2:0] pmc_cause_t;

    // mode control register layout and reset value
    localparam int CTRL_W = 2;
    localparam int CTRL_LVL_BIT = 0;
    localparam int CTRL_SP_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;

    // stack pointers: word aligned, low bits ignored
    localparam int SP_W = 32;
    localparam int SP_LOW_BITS = 2;
    localparam logic [31:0] SP_RST = 32'h0000_0000;

    // restricted access classes, one bit each
    localparam int ACC_W = 4;
    localparam int ACC_PRIV_INSTR = 0;
    localparam int ACC_SPECIAL = 1;
    localparam int ACC_CONFIG = 2;
    localparam int ACC_DEBUG = 3;

    // fault causes
    localparam pmc_cause_t FLT_NONE = 3'h0;
    localparam pmc_cause_t FLT_ACCESS = 3'h1;
    localparam pmc_cause_t FLT_CTRL_WR = 3'h2;
    localparam pmc_cause_t FLT_ISA = 3'h3;

    // exception nesting depth counter width
    localparam int NEST_W = 4;

    // address map: 32-bit space, region index in the top bits
    localparam int ADDR_W = 32;
    localparam int REGION_MSB = 31;
    localparam int REGION_LSB = 29;
    localparam logic [2:0] REGION_CODE_LAST = 3'h0;
    localparam logic [2:0] REGION_DATA_LAST = 3'h1;
    localparam logic [2:0] BUS_CODE = 3'b001;
    localparam logic [2:0] BUS_DATA = 3'b010;
    localparam logic [2:0] BUS_PERIPH = 3'b100;

    // bit-band alias window and its target
    localparam logic [31:0] BB_ALIAS_BASE = 32'h3200_0000;
    localparam logic [31:0] BB_TARGET_BASE = 32'h3000_0000;
    localparam int BB_SPAN_BITS = 25;
    localparam int BB_BIT_W = 5;

    // access sizes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
endpackage

// file: verification/test_cpu_privilege_mode_control.sv
// Purpose: self-checking bench for the privilege mode control block
// Assumes: pulses driven 2 ns after the rising edge, results read at negedge, mode checked 2 ns after the edge
// Notes: access and memory results are queued and matched by a monitor
`timescale 1ns/1ps
module test_cpu_privilege_mode_control;
    typedef struct packed {logic grant; logic fault; logic [2:0] cause;} pmc_acc_exp_t;
    typedef struct packed {
        logic [2:0] sel; logic [31:0] addr; logic bb; logic [4:0] bidx; logic unal;
    } pmc_mem_exp_t;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic external_reset_n_i = 1'b1;
    logic exc_entry_i = 1'b0, exc_return_i = 1'b0, ctrl_wr_i = 1'b0;
    logic [1:0] ctrl_wdata_i = 2'h0;
    logic sp_wr_i = 1'b0;
    logic [31:0] sp_wdata_i = 32'h0;
    logic acc_valid_i = 1'b0, instr_valid_i = 1'b0, instr_classic_i = 1'b0;
    logic [3:0] acc_class_i = 4'h0;
    logic mem_valid_i = 1'b0;
    logic [31:0] mem_addr_i = 32'h0;
    logic [1:0] mem_size_i = 2'h0;
    logic [2:0] state_o, fault_cause_o, bus_sel_o;
    logic privileged_o, handler_o, sp_process_o, acc_grant_o, fault_o;
    logic mem_valid_o, bitband_o, unaligned_o;
    logic [1:0] ctrl_o;
    logic [31:0] active_sp_o, bus_addr_o;
    logic [4:0] bb_bit_o;
    int err_count = 0;
    int n_tests = 0;
    int depth = 0;
    logic [1:0] exp_ctrl = 2'h0;
    logic [31:0] main_sp = 32'h0, proc_sp = 32'h0;
    logic [31:0] seed = 32'h13112381;
    pmc_acc_exp_t acc_q[$];
    pmc_mem_exp_t mem_q[$];

    always #25 clk_i = ~clk_i;

    pmc_mode_ctrl u_pmc_mode_ctrl (
        .clk_i(clk_i), .reset_i(reset_i), .external_reset_n_i(external_reset_n_i),
        .exc_entry_i(exc_entry_i), .exc_return_i(exc_return_i),
        .ctrl_wr_i(ctrl_wr_i), .ctrl_wdata_i(ctrl_wdata_i),
        .sp_wr_i(sp_wr_i), .sp_wdata_i(sp_wdata_i),
        .acc_valid_i(acc_valid_i), .acc_class_i(acc_class_i),
        .instr_valid_i(instr_valid_i), .instr_classic_i(instr_classic_i),
        .mem_valid_i(mem_valid_i), .mem_addr_i(mem_addr_i), .mem_size_i(mem_size_i),
        .state_o(state_o), .privileged_o(privileged_o), .handler_o(handler_o),
        .ctrl_o(ctrl_o), .active_sp_o(active_sp_o), .sp_process_o(sp_process_o),
        .acc_grant_o(acc_grant_o), .fault_o(fault_o), .fault_cause_o(fault_cause_o),
        .mem_valid_o(mem_valid_o), .bus_sel_o(bus_sel_o), .bus_addr_o(bus_addr_o),
        .bitband_o(bitband_o), .bb_bit_o(bb_bit_o), .unaligned_o(unaligned_o)
    );

    // xorshift source, fixed start so every run is the same
    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic cyc();
        @(posedge clk_i);
        #2;
    endtask

    // all pulse lines written once per step, so no stale pulse lingers
    task automatic drive(input logic [6:0] p);
        {exc_entry_i, exc_return_i, ctrl_wr_i, sp_wr_i,
         acc_valid_i, instr_valid_i, mem_valid_i} = p;
    endtask

    // drop every pulse, then let one edge pass
    task automatic quiet();
        drive(7'h00);
        cyc();
    endtask

    // bench view of user level and process pointer selection
    function automatic logic is_user();
        return depth == 0 && exp_ctrl[0];
    endfunction

    task automatic mode_chk();
        logic [2:0] st;
        st = (depth > 0) ? 3'b100 : (exp_ctrl[0] ? 3'b010 : 3'b001);
        check("mode", {24'h0, st, !is_user(), depth > 0,
              (depth > 0) ? {1'b0, exp_ctrl[0]} : exp_ctrl, is_user() && exp_ctrl[1]},
              {24'h0, state_o, privileged_o, handler_o, ctrl_o, sp_process_o});
        check("active sp",
              (is_user() && exp_ctrl[1]) ? proc_sp : main_sp, active_sp_o);
    endtask

    task automatic acc(input logic is_instr, input logic [3:0] cls, input logic classic);
        drive({4'h0, !is_instr, is_instr, 1'b0});
        acc_class_i = cls; instr_classic_i = classic;
        // compact encoding gives no pulse; any answer to it is unexpected
        if (is_instr) begin
            if (classic) acc_q.push_back('{1'b0, 1'b1, 3'h3});
        end else if (is_user() && cls != 4'h0) begin
            acc_q.push_back('{1'b0, 1'b1, 3'h1});
        end else begin
            acc_q.push_back('{1'b1, 1'b0, 3'h0});
        end
        cyc();
    endtask

    task automatic ctrl_wr(input logic [1:0] d);
        drive(7'h10); ctrl_wdata_i = d;
        if (is_user()) acc_q.push_back('{1'b0, 1'b1, 3'h2}); // refused, level kept
        else if (depth > 0) exp_ctrl = {1'b0, d[0]};
        else exp_ctrl = d;
        cyc();
    endtask

    task automatic exc(input logic ent, input logic ret);
        drive({ent, ret, 5'h00});
        if (ent && !ret && depth < 15) depth++;
        else if (ret && !ent && depth > 0) depth--;
        cyc();
    endtask

    task automatic sp_wr(input logic [31:0] d);
        drive(7'h08); sp_wdata_i = d;
        if (is_user() && exp_ctrl[1]) proc_sp = {d[31:2], 2'b00};
        else main_sp = {d[31:2], 2'b00};
        cyc();
    endtask

    task automatic mem(input logic [31:0] a, input logic [1:0] sz);
        pmc_mem_exp_t e;
        logic [31:0] off;
        off = a - pmc_pkg::BB_ALIAS_BASE;
        e.bb = (a >= pmc_pkg::BB_ALIAS_BASE) && (off[31:25] == 7'h0);
        e.addr = e.bb ? pmc_pkg::BB_TARGET_BASE + 32'({off[24:7], 2'b00}) : a;
        e.bidx = e.bb ? off[6:2] : 5'h0;
        e.sel = (a[31:29] == 3'h0) ? 3'b001 : ((a[31:29] == 3'h1) ? 3'b010 : 3'b100);
        e.unal = (sz == 2'h1) ? a[0] : ((sz[1]) ? (a[1:0] != 2'h0) : 1'b0);
        drive(7'h01); mem_addr_i = a; mem_size_i = sz;
        mem_q.push_back(e);
        cyc();
    endtask

    // monitor: each result pulse takes the oldest note off its queue
    always @(negedge clk_i) begin
        pmc_acc_exp_t a;
        pmc_mem_exp_t m;
        if (acc_grant_o === 1'b1 || fault_o === 1'b1) begin
            if (acc_q.size() == 0)
                check("unexpected access", 32'h0, 32'h1);
            else begin
                a = acc_q.pop_front();
                check("access result", {27'h0, a}, {27'h0, acc_grant_o, fault_o, fault_cause_o});
            end
        end
        if (mem_valid_o === 1'b1) begin
            if (mem_q.size() == 0)
                check("unexpected mem", 32'h0, 32'h1);
            else begin
                m = mem_q.pop_front();
                check("bus addr", m.addr, bus_addr_o);
                check("mem flags", {22'h0, m.sel, m.bb, m.bidx, m.unal}, {22'h0, bus_sel_o,
                      bitband_o, bitband_o ? bb_bit_o : 5'h0, unaligned_o});
            end
        end
    end

    // hang guard
    initial begin
        for (int k = 0; k < 5000; k++) @(posedge clk_i);
        check("run time limit", 32'h0, 32'h1);
        report_and_stop();
    end

    initial begin
        logic [31:0] r;
        repeat (6) @(posedge clk_i);
        #2 reset_i = 1'b0;
        cyc();
        cyc();
        mode_chk();
        // privileged thread: everything granted, classic encoding faults
        for (int i = 0; i < 8; i++) acc(1'b0, 4'(next_rand()), 1'b0);
        acc(1'b1, 4'h0, 1'b0);
        acc(1'b1, 4'h0, 1'b1);
        quiet();
        sp_wr(32'h0000_1003); quiet(); mode_chk();
        ctrl_wr(2'b11); quiet(); mode_chk();
        sp_wr(next_rand()); quiet(); mode_chk();
        // user thread: each restricted class faults, class zero granted, classic encoding faults
        for (int i = 0; i < 4; i++) acc(1'b0, 4'h1 << i, 1'b0);
        acc(1'b0, 4'h0, 1'b0);
        acc(1'b1, 4'h0, 1'b1);
        ctrl_wr(2'b00); quiet(); mode_chk();
        exc(1'b1, 1'b0); quiet(); mode_chk();
        acc(1'b0, 4'hf, 1'b0);
        ctrl_wr(2'b11);
        exc(1'b1, 1'b0); exc(1'b1, 1'b1); exc(1'b0, 1'b1);
        quiet(); mode_chk();
        exc(1'b0, 1'b1); quiet(); mode_chk();
        exc(1'b0, 1'b1); quiet(); mode_chk();
        // memory map, bit-band window edges and alignment
        mem(32'h3200_0084, 2'h2);
        mem(32'h33ff_fffc, 2'h2);
        mem(32'h1fff_ffff, 2'h1);
        mem(32'h2000_0002, 2'h2);
        mem(32'h4000_0001, 2'h0);
        for (int i = 0; i < 24; i++) begin
            r = next_rand();
            mem((i % 3 == 0) ? (pmc_pkg::BB_ALIAS_BASE | {7'h0, r[24:0]}) : r, r[31:30]);
        end
        quiet();
        // reset pin taken low while inside a handler
        exc(1'b1, 1'b0); quiet();
        external_reset_n_i = 1'b0;
        repeat (4) cyc();
        depth = 0; exp_ctrl = 2'h0; main_sp = 32'h0; proc_sp = 32'h0;
        mode_chk();
        external_reset_n_i = 1'b1;
        repeat (4) cyc();
        mode_chk();
        acc(1'b0, 4'h2, 1'b0);
        quiet();
        repeat (3) cyc();
        check("pending notes", 32'h0, 32'(acc_q.size() + mem_q.size()));
        report_and_stop();
    end
endmodule // test_cpu_privilege_mode_control

// file: verilog/pmc_addr_map.sv
// Purpose: region decode, bit-band alias translation, alignment flag
// Assumes: combinational, one address per cycle
// Notes: unaligned accesses are flagged only, never refused
`timescale 1ns/1ps
module pmc_addr_map #(
    parameter logic [31:0] BB_ALIAS = pmc_pkg::BB_ALIAS_BASE,
    parameter logic [31:0] BB_TARGET = pmc_pkg::BB_TARGET_BASE
) (
    pmc_link_if.map link
);
    logic [2:0] region_w;
    logic [31:0] bb_off_w;

    // one bus each for code (region 0) and data (region 1), one shared by regions 2 to 7, so the three run in parallel
    assign region_w = link.addr[pmc_pkg::REGION_MSB:pmc_pkg::REGION_LSB];
    assign link.bus_sel = (region_w <= pmc_pkg::REGION_CODE_LAST) ?
                              pmc_pkg::BUS_CODE :
                          (region_w <= pmc_pkg::REGION_DATA_LAST) ?
                              pmc_pkg::BUS_DATA :
                              pmc_pkg::BUS_PERIPH;

    // each alias word stands for one bit of the target window
    assign bb_off_w = link.addr - BB_ALIAS;
    assign link.bb_hit = bb_off_w[31:pmc_pkg::BB_SPAN_BITS] == '0;
    assign link.bb_word = BB_TARGET +
        {12'h000, bb_off_w[pmc_pkg::BB_SPAN_BITS-1:7], 2'h0};
    assign link.bb_bit = bb_off_w[6:2];

    // byte access is never misaligned; flag only, data goes through
    assign link.unaligned = (link.size == pmc_pkg::SIZE_BYTE) ? 1'b0 :
                            (link.size == pmc_pkg::SIZE_HALF) ?
                                link.addr[0] :
                                (link.addr[1:0] != 2'h0);
endmodule // pmc_addr_map

// file: verilog/pmc_mode_ctrl.sv
// Purpose: privilege level, thread/handler mode and stack selection
// Assumes: single clock, reset pin low active, exception events as pulses
// Notes: all outputs registered; active pointer lags its cause two cycles
`timescale 1ns/1ps
// Notes on behaviour
// - only privileged thread, user thread, handler
// - exception means handler, privileged; else thread
// - user level restricted access faults, blocked
// - privileged level grants everything, no fault
// - two stack pointers, either one active
// - only compact mixed encodings; classic faults
// - bit-band alias gives atomic bit access
// - unaligned loads and stores accepted
// - 32-bit map, regions on separate buses
// - low reset pin holds reset; pull-up outside
// - process pointer only in user thread
// - bit0 level, bit1 stack; bit1 zero handler
module pmc_mode_ctrl #(
    parameter int NEST_W = pmc_pkg::NEST_W
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic external_reset_n_i,
    input wire logic exc_entry_i,
    input wire logic exc_return_i,
    input wire logic ctrl_wr_i,
    input wire logic [1:0] ctrl_wdata_i,
    input wire logic sp_wr_i,
    input wire logic [31:0] sp_wdata_i,
    input wire logic acc_valid_i,
    input wire logic [3:0] acc_class_i,
    input wire logic instr_valid_i,
    input wire logic instr_classic_i,
    input wire logic mem_valid_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [1:0] mem_size_i,
    output logic [2:0] state_o,
    output logic privileged_o,
    output logic handler_o,
    output logic [1:0] ctrl_o,
    output logic [31:0] active_sp_o,
    output logic sp_process_o,
    output logic acc_grant_o,
    output logic fault_o,
    output logic [2:0] fault_cause_o,
    output logic mem_valid_o,
    output logic [2:0] bus_sel_o,
    output logic [31:0] bus_addr_o,
    output logic bitband_o,
    output logic [4:0] bb_bit_o,
    output logic unaligned_o
);
    localparam logic [NEST_W-1:0] NEST_ONE = {{(NEST_W-1){1'b0}}, 1'b1};
    localparam logic [NEST_W-1:0] NEST_ZERO = {NEST_W{1'b0}};
    localparam logic [NEST_W-1:0] NEST_FULL = {NEST_W{1'b1}};

    pmc_link_if link ();

    // reset pin synchroniser; first stage read by the second only
    logic xr_meta_q;
    logic xr_sync_q;
    logic rst_w;

    pmc_pkg::pmc_state_t state_q;
    pmc_pkg::pmc_state_t state_d;
    pmc_pkg::pmc_state_t thread_st_w;
    logic [1:0] ctrl_q;
    logic [1:0] ctrl_d;
    logic [NEST_W-1:0] depth_q;
    logic [NEST_W-1:0] depth_d;
    logic user_w;
    logic handler_w;
    logic handler_d_w;
    logic ret_w;
    logic last_ret_w;
    logic ctrl_ok_w;
    logic drop_w;
    logic isa_flt_w;
    logic acc_blk_w;
    logic ctl_blk_w;
    pmc_pkg::pmc_cause_t cause_d;
    logic sel_psp_w;
    logic [31:0] sp_mask_w;
    logic [4:0] bb_bit_w;

    logic priv_q;
    logic handler_q;
    logic [1:0] ctrl_view_q;
    logic [31:0] active_sp_q;
    logic sp_proc_q;
    logic grant_q;
    logic fault_q;
    pmc_pkg::pmc_cause_t cause_q;
    logic mem_valid_q;
    logic [2:0] bus_sel_q;
    logic [31:0] bus_addr_q;
    logic bb_q;
    logic [4:0] bb_bit_q;
    logic unal_q;

    // two flops on the pin; the outside pull-up keeps it high when idle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            xr_meta_q <= 1'b0;
            xr_sync_q <= 1'b0;
        end else begin
            xr_meta_q <= external_reset_n_i;
            xr_sync_q <= xr_meta_q;
        end
    end
    assign rst_w = reset_i | ~xr_sync_q;

    // state decode
    assign user_w = state_q == pmc_pkg::PMC_USER_THREAD;
    assign handler_w = state_q == pmc_pkg::PMC_HANDLER;
    assign thread_st_w = ctrl_q[pmc_pkg::CTRL_LVL_BIT] ?
        pmc_pkg::PMC_USER_THREAD : pmc_pkg::PMC_PRIV_THREAD;

    // a return with no exception open is dropped
    assign ret_w = exc_return_i && (depth_q != NEST_ZERO);
    assign last_ret_w = ret_w && !exc_entry_i && (depth_q == NEST_ONE);

    // control writes: privileged only, stack bit forced low in handler
    assign ctrl_ok_w = ctrl_wr_i && !user_w;
    assign ctrl_d = ctrl_ok_w ?
        {ctrl_wdata_i[pmc_pkg::CTRL_SP_BIT] & ~handler_w,
         ctrl_wdata_i[pmc_pkg::CTRL_LVL_BIT]} : ctrl_q;
    assign drop_w = (state_q == pmc_pkg::PMC_PRIV_THREAD) && ctrl_ok_w &&
                    ctrl_wdata_i[pmc_pkg::CTRL_LVL_BIT];

    // next state: entry beats return; user never climbs on its own
    assign state_d = exc_entry_i ? pmc_pkg::PMC_HANDLER :
                     last_ret_w ? thread_st_w :
                     drop_w ? pmc_pkg::PMC_USER_THREAD :
                     state_q;
    assign handler_d_w = state_d == pmc_pkg::PMC_HANDLER;

    // nesting depth, saturating at the top
    assign depth_d = (exc_entry_i && !ret_w && depth_q != NEST_FULL) ?
                         depth_q + NEST_ONE :
                     (ret_w && !exc_entry_i) ? depth_q - NEST_ONE :
                     depth_q;

    always_ff @(posedge clk_i) begin
        if (rst_w) begin
            state_q <= pmc_pkg::PMC_PRIV_THREAD;
            ctrl_q <= pmc_pkg::CTRL_RST;
            depth_q <= NEST_ZERO;
        end else begin
            state_q <= state_d;
            ctrl_q <= ctrl_d;
            depth_q <= depth_d;
        end
    end

    // fault decode; an encoding fault outranks an access fault
    assign isa_flt_w = instr_valid_i && instr_classic_i;
    assign acc_blk_w = acc_valid_i && user_w && (|acc_class_i);
    assign ctl_blk_w = ctrl_wr_i && user_w;
    assign cause_d = isa_flt_w ? pmc_pkg::FLT_ISA :
                     acc_blk_w ? pmc_pkg::FLT_ACCESS :
                     ctl_blk_w ? pmc_pkg::FLT_CTRL_WR :
                     pmc_pkg::FLT_NONE;

    // process pointer needs user thread and the stack bit both
    assign sel_psp_w = user_w && ctrl_q[pmc_pkg::CTRL_SP_BIT];
    assign link.sel_psp = sel_psp_w;
    assign link.sp_wr = sp_wr_i;
    assign link.sp_wdata = sp_wdata_i;
    assign link.addr = mem_addr_i;
    assign link.size = mem_size_i;

    pmc_sp_bank u_bank (
        .clk_i(clk_i),
        .rst_i(rst_w),
        .link(link)
    );

    pmc_addr_map u_map (
        .link(link)
    );

    // level, handler and control view follow the next state so they agree with state_o
    always_ff @(posedge clk_i) begin
        if (rst_w) begin
            priv_q <= 1'b1;
            handler_q <= 1'b0;
            ctrl_view_q <= pmc_pkg::CTRL_RST;
            active_sp_q <= pmc_pkg::SP_RST;
            sp_proc_q <= 1'b0;
        end else begin
            priv_q <= state_d != pmc_pkg::PMC_USER_THREAD;
            handler_q <= handler_d_w;
            ctrl_view_q <= {ctrl_d[pmc_pkg::CTRL_SP_BIT] & ~handler_d_w,
                            ctrl_d[pmc_pkg::CTRL_LVL_BIT]};
            active_sp_q <= link.active_sp;
            sp_proc_q <= sel_psp_w;
        end
    end

    // access answer and fault pulse, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_w) begin
            grant_q <= 1'b0;
            fault_q <= 1'b0;
            cause_q <= pmc_pkg::FLT_NONE;
        end else begin
            grant_q <= acc_valid_i && !acc_blk_w;
            fault_q <= cause_d != pmc_pkg::FLT_NONE;
            cause_q <= cause_d;
        end
    end

    // memory route: alias hits go out as their target word
    always_ff @(posedge clk_i) begin
        if (rst_w) begin
            mem_valid_q <= 1'b0;
            bus_sel_q <= 3'h0;
            bus_addr_q <= 32'h0000_0000;
            bb_q <= 1'b0;
            bb_bit_q <= 5'h00;
            unal_q <= 1'b0;
        end else begin
            mem_valid_q <= mem_valid_i;
            bus_sel_q <= mem_valid_i ? link.bus_sel : 3'h0;
            bus_addr_q <= link.bb_hit ? link.bb_word : mem_addr_i;
            bb_q <= mem_valid_i && link.bb_hit;
            bb_bit_q <= link.bb_bit;
            unal_q <= mem_valid_i && link.unaligned;
        end
    end

    assign state_o = state_q;
    assign privileged_o = priv_q;
    assign handler_o = handler_q;
    assign ctrl_o = ctrl_view_q;
    assign active_sp_o = active_sp_q;
    assign sp_process_o = sp_proc_q;
    assign acc_grant_o = grant_q;
    assign fault_o = fault_q;
    assign fault_cause_o = cause_q;
    assign mem_valid_o = mem_valid_q;
    assign bus_sel_o = bus_sel_q;
    assign bus_addr_o = bus_addr_q;
    assign bitband_o = bb_q;
    assign bb_bit_o = bb_bit_q;
    assign unaligned_o = unal_q;

    // helpers read only by the checks
    assign sp_mask_w = {sp_wdata_i[31:2], 2'h0};
    assign bb_bit_w = mem_addr_i[6:2];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_w);

    three_states_a: assert property (
        $onehot(state_q) && !(handler_o && !privileged_o))
        else $error("illegal execution state");
    entry_handler_a: assert property (
        exc_entry_i |=> handler_o && privileged_o &&
                        state_q == pmc_pkg::PMC_HANDLER)
        else $error("exception entry did not reach handler");
    return_level_a: assert property (
        last_ret_w |=> state_q == ($past(ctrl_q[0]) ?
            pmc_pkg::PMC_USER_THREAD : pmc_pkg::PMC_PRIV_THREAD))
        else $error("exception return gave wrong level");
    user_stays_a: assert property (
        user_w && !exc_entry_i |=> user_w && !privileged_o)
        else $error("user level left without exception");
    user_block_a: assert property (
        acc_blk_w && !isa_flt_w |=> fault_o && !acc_grant_o &&
                                    fault_cause_o == pmc_pkg::FLT_ACCESS)
        else $error("restricted access at user level not faulted");
    // an entry right after the refused write may legally clear the view
    user_ctrl_a: assert property (
        ctl_blk_w && !exc_entry_i ##1 !exc_entry_i
            |-> $stable(ctrl_q) ##1 $stable(ctrl_o))
        else $error("user level changed the mode control");
    priv_grant_a: assert property (
        acc_valid_i && !user_w && !isa_flt_w |=> acc_grant_o && !fault_o)
        else $error("privileged access refused");
    isa_fault_a: assert property (
        isa_flt_w |=> fault_o && fault_cause_o == pmc_pkg::FLT_ISA)
        else $error("classic encoding not faulted");
    psp_user_a: assert property (
        sp_process_o |-> $past(user_w))
        else $error("process pointer outside user thread");
    sp_write_a: assert property (
        sp_wr_i && !exc_entry_i && !exc_return_i && !ctrl_wr_i
            |-> ##2 active_sp_o == $past(sp_mask_w, 2))
        else $error("stack pointer write lost");
    handler_bit_a: assert property (
        handler_o |-> !ctrl_o[1])
        else $error("stack bit set in handler mode");
    bitband_a: assert property (
        mem_valid_i && link.bb_hit |=> bitband_o &&
                                       bb_bit_o == $past(bb_bit_w))
        else $error("bit-band alias not translated");
    region_a: assert property (
        mem_valid_i |=> $onehot(bus_sel_o))
        else $error("address decoded to no single bus");

    user_fault_c: cover property (acc_blk_w ##1 fault_o);
    user_entry_c: cover property (user_w && exc_entry_i ##1 handler_o);
    nested_ret_c: cover property (depth_q == 4'h2 ##[1:20] last_ret_w);
endmodule // pmc_mode_ctrl

// file: verilog/pmc_sp_bank.sv
// Purpose: banked main and process stack pointers
// Assumes: synchronous reset, selection given by the mode logic
// Notes: the active pointer is a plain mux, registered by the top
`timescale 1ns/1ps
module pmc_sp_bank (
    input wire logic clk_i,
    input wire logic rst_i,
    pmc_link_if.bank link
);
    logic [31:0] main_stack_pointer_q;
    logic [31:0] process_stack_pointer_q;
    logic [31:0] wmask_w;

    // low bits always read as zero, so the pointer stays word aligned
    assign wmask_w = {link.sp_wdata[31:pmc_pkg::SP_LOW_BITS],
                      {pmc_pkg::SP_LOW_BITS{1'b0}}};
    assign link.active_sp = link.sel_psp ? process_stack_pointer_q
                                         : main_stack_pointer_q;

    // writes land in whichever pointer is active now
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            main_stack_pointer_q <= pmc_pkg::SP_RST;
            process_stack_pointer_q <= pmc_pkg::SP_RST;
        end else if (link.sp_wr) begin
            if (link.sel_psp) begin
                process_stack_pointer_q <= wmask_w;
            end else begin
                main_stack_pointer_q <= wmask_w;
            end
        end
    end
endmodule // pmc_sp_bank
